// ### hdl/otg_event_enables.sv
`timescale 1ns/1ps
module otg_event_enables (
   input  wire logic        i_clk,
   input  wire logic        i_sys_rst,
   input  wire logic        i_ce,
   input  wire logic        i_id_ground_level,
   input  wire logic        i_session_end_level,
   input  wire logic        i_session_valid_level,
   input  wire logic        i_bus_power_valid_level,
   input  wire logic        i_host_disconnect_level,
   input  wire logic        i_low_power,
   input  wire logic        i_reg_wr,
   input  wire logic        i_reg_rd,
   input  wire logic [5:0]  i_reg_addr,
   input  wire logic [7:0]  i_reg_wdata,
   output logic [7:0]       o_reg_rdata,
   output logic             o_reg_rvalid,
   output logic             o_irq,
   output logic             o_rxcmd_req,
   output logic [4:0]       o_rxcmd_levels
);
   enable_wr_if rise_if ();
   enable_wr_if fall_if ();

   logic [4:0] raw;
   logic [4:0] level;
   logic [4:0] rise;
   logic [4:0] fall;
   logic [4:0] hit;
   logic [4:0] latch_ff;
   logic [4:0] nxt_latch;
   logic       latch_rd;
   logic [7:0] rd_mux;
   logic [7:0] rdata_ff;
   logic       rvalid_ff;
   logic       irq_ff;
   logic       rxcmd_ff;
   logic [4:0] rxlvl_ff;

   // ----------------------------------------------------------------
   // Source mapping
   // ----------------------------------------------------------------
   assign raw[otg_event_pkg::BIT_ID_GROUND]     = i_id_ground_level;
   assign raw[otg_event_pkg::BIT_SESSION_END]   = i_session_end_level;
   assign raw[otg_event_pkg::BIT_SESSION_VALID] = i_session_valid_level;
   assign raw[otg_event_pkg::BIT_BUS_VLD]   = i_bus_power_valid_level;
   assign raw[otg_event_pkg::BIT_HOST_DISC] = i_host_disconnect_level;

   otg_edge_detect u_edge (
      .i_clk     (i_clk),
      .i_sys_rst (i_sys_rst),
      .i_ce      (i_ce),
      .i_raw     (raw),
      .o_level   (level),
      .o_rise    (rise),
      .o_fall    (fall)
   );

   // ----------------------------------------------------------------
   // Enable register write decode
   // ----------------------------------------------------------------
   function automatic otg_event_pkg::wr_kind_e wr_kind(input logic       wr,
                                                       input logic [5:0] addr,
                                                       input logic [5:0] base);
      if (!wr)
         return otg_event_pkg::WR_NONE;
      else if (addr == base)
         return otg_event_pkg::WR_LOAD;
      else if (addr == base + otg_event_pkg::ADDR_SET_STEP)
         return otg_event_pkg::WR_SET;
      else if (addr == base + otg_event_pkg::ADDR_CLR_STEP)
         return otg_event_pkg::WR_CLR;
      else
         return otg_event_pkg::WR_NONE;
   endfunction

   assign rise_if.kind = wr_kind(i_reg_wr, i_reg_addr, otg_event_pkg::ADDR_RISE_WR);
   assign rise_if.data = i_reg_wdata[4:0];
   assign fall_if.kind = wr_kind(i_reg_wr, i_reg_addr, otg_event_pkg::ADDR_FALL_WR);
   assign fall_if.data = i_reg_wdata[4:0];

   otg_enable_reg u_rise_en (
      .i_clk     (i_clk),
      .i_sys_rst (i_sys_rst),
      .i_ce      (i_ce),
      .wr        (rise_if.holder)
   );

   otg_enable_reg u_fall_en (
      .i_clk     (i_clk),
      .i_sys_rst (i_sys_rst),
      .i_ce      (i_ce),
      .wr        (fall_if.holder)
   );

   // ----------------------------------------------------------------
   // Event qualification and latch
   // ----------------------------------------------------------------
   assign hit      = (rise & rise_if.value) | (fall & fall_if.value);
   assign latch_rd = i_reg_rd && (i_reg_addr == otg_event_pkg::ADDR_LATCH);
   // A new event wins over the read that clears, so it is never lost
   assign nxt_latch = ((latch_rd || i_low_power) ? otg_event_pkg::LATCH_RESET : latch_ff)
                      | hit;

   // ----------------------------------------------------------------
   // Read mux; reserved bits read zero
   // ----------------------------------------------------------------
   assign rd_mux =
      (i_reg_addr == otg_event_pkg::ADDR_RISE_WR ||
       i_reg_addr == otg_event_pkg::ADDR_RISE_SET ||
       i_reg_addr == otg_event_pkg::ADDR_RISE_CLR) ?
         {otg_event_pkg::RSVD_ZERO, rise_if.value} :
      (i_reg_addr == otg_event_pkg::ADDR_FALL_WR ||
       i_reg_addr == otg_event_pkg::ADDR_FALL_SET ||
       i_reg_addr == otg_event_pkg::ADDR_FALL_CLR) ?
         {otg_event_pkg::RSVD_ZERO, fall_if.value} :
      (i_reg_addr == otg_event_pkg::ADDR_LEVELS) ?
         {otg_event_pkg::RSVD_ZERO, level} :
      (i_reg_addr == otg_event_pkg::ADDR_LATCH) ?
         {otg_event_pkg::RSVD_ZERO, latch_ff} : 8'h00;

   // Latch and read data
   always_ff @(posedge i_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         latch_ff  <= otg_event_pkg::LATCH_RESET;
         rdata_ff  <= 8'h00;
         rvalid_ff <= 1'b0;
      end else if (i_ce) begin
         latch_ff  <= nxt_latch;
         rdata_ff  <= i_reg_rd ? rd_mux : rdata_ff;
         rvalid_ff <= i_reg_rd;
      end
   end

   // Interrupt and receive-command pulse, one cycle for each cycle with any enabled edge
   always_ff @(posedge i_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         irq_ff   <= 1'b0;
         rxcmd_ff <= 1'b0;
         rxlvl_ff <= 5'h00;
      end else if (i_ce) begin
         irq_ff   <= |hit;
         rxcmd_ff <= |hit;
         rxlvl_ff <= level;  // Level snapshot rides with the command
      end
   end

   assign o_reg_rdata    = rdata_ff;
   assign o_reg_rvalid   = rvalid_ff;
   assign o_irq          = irq_ff;
   assign o_rxcmd_req    = rxcmd_ff;
   assign o_rxcmd_levels = rxlvl_ff;

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   rise_event_irq_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      (i_ce && |(rise & rise_if.value)) |=> (o_irq && o_rxcmd_req))
      else $error("enabled rising change gave no interrupt");
   fall_event_irq_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      (i_ce && |(fall & fall_if.value)) |=> (o_irq && o_rxcmd_req))
      else $error("enabled falling change gave no interrupt");
   masked_no_irq_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      (i_ce && ((rise & ~rise_if.value) | (fall & ~fall_if.value)) == (rise | fall)
       && |(rise | fall)) |=> !o_irq)
      else $error("masked change gave an interrupt");
   levels_read_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      (i_ce && i_reg_rd && i_reg_addr == otg_event_pkg::ADDR_LEVELS)
      |=> (o_reg_rdata == {otg_event_pkg::RSVD_ZERO, $past(level)}))
      else $error("levels read wrong");
   rise_read_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      (i_ce && i_reg_rd && i_reg_addr == otg_event_pkg::ADDR_RISE_SET)
      |=> (o_reg_rdata[7:5] == otg_event_pkg::RSVD_ZERO &&
           o_reg_rdata[4:0] == $past(rise_if.value)))
      else $error("rise enable read wrong");
   fall_read_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      (i_ce && i_reg_rd && i_reg_addr == otg_event_pkg::ADDR_FALL_CLR)
      |=> (o_reg_rdata[4:0] == $past(fall_if.value)))
      else $error("fall enable read wrong");
   latch_set_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      (i_ce && |hit) |=> ((latch_ff & $past(hit)) == $past(hit)))
      else $error("event not latched");
   latch_clear_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      (i_ce && i_low_power && hit == 5'h00) |=> (latch_ff == 5'h00))
      else $error("latch not cleared in low power");
   load_write_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      (i_ce && i_reg_wr && i_reg_addr == otg_event_pkg::ADDR_RISE_WR)
      |=> (rise_if.value == $past(i_reg_wdata[4:0])))
      else $error("rise enable write not loaded");
   reset_enable_a: assert property (@(posedge i_clk)
      $fell(i_sys_rst) |-> (rise_if.value == otg_event_pkg::ENABLE_RESET &&
                            fall_if.value == otg_event_pkg::ENABLE_RESET))
      else $error("enables not all set after reset");

   // ----------------------------------------------------------------
   // Checks: register bus
   // ----------------------------------------------------------------
   rvalid_pulse_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      i_ce
      |=> (o_reg_rvalid == $past(i_reg_rd)))
      else $error("read valid pulse wrong");
   rdata_hold_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      (i_ce && !i_reg_rd)
      |=> $stable(o_reg_rdata))
      else $error("read data moved without a read");
   rise_wr_read_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      (i_ce && i_reg_rd && i_reg_addr == otg_event_pkg::ADDR_RISE_WR)
      |=> (o_reg_rdata == {otg_event_pkg::RSVD_ZERO, $past(rise_if.value)}))
      else $error("rise enable read wrong");
   rise_clr_read_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      (i_ce && i_reg_rd && i_reg_addr == otg_event_pkg::ADDR_RISE_CLR)
      |=> (o_reg_rdata == {otg_event_pkg::RSVD_ZERO, $past(rise_if.value)}))
      else $error("rise enable read wrong");
   fall_wr_read_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      (i_ce && i_reg_rd && i_reg_addr == otg_event_pkg::ADDR_FALL_WR)
      |=> (o_reg_rdata == {otg_event_pkg::RSVD_ZERO, $past(fall_if.value)}))
      else $error("fall enable read wrong");
   fall_set_read_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      (i_ce && i_reg_rd && i_reg_addr == otg_event_pkg::ADDR_FALL_SET)
      |=> (o_reg_rdata == {otg_event_pkg::RSVD_ZERO, $past(fall_if.value)}))
      else $error("fall enable read wrong");
   unmapped_read_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      (i_ce && i_reg_rd && (i_reg_addr < otg_event_pkg::ADDR_RISE_WR ||
       i_reg_addr > otg_event_pkg::ADDR_LATCH)) |=> (o_reg_rdata == 8'h00))
      else $error("unmapped read not zero");
   unmapped_write_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      (i_ce && i_reg_wr && (i_reg_addr < otg_event_pkg::ADDR_RISE_WR ||
       i_reg_addr > otg_event_pkg::ADDR_FALL_CLR))
      |=> ($stable(rise_if.value) && $stable(fall_if.value)))
      else $error("unmapped write changed an enable");
   rise_set_wr_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      (i_ce && rise_if.kind == otg_event_pkg::WR_SET)
      |=> (rise_if.value == $past(rise_if.value | rise_if.data)))
      else $error("rise enable set wrong");
   rise_clr_wr_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      (i_ce && rise_if.kind == otg_event_pkg::WR_CLR)
      |=> (rise_if.value == $past(rise_if.value & ~rise_if.data)))
      else $error("rise enable clear wrong");
   fall_load_wr_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      (i_ce && fall_if.kind == otg_event_pkg::WR_LOAD)
      |=> (fall_if.value == $past(fall_if.data)))
      else $error("fall enable write not loaded");
   fall_set_wr_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      (i_ce && fall_if.kind == otg_event_pkg::WR_SET)
      |=> (fall_if.value == $past(fall_if.value | fall_if.data)))
      else $error("fall enable set wrong");
   fall_clr_wr_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      (i_ce && fall_if.kind == otg_event_pkg::WR_CLR)
      |=> (fall_if.value == $past(fall_if.value & ~fall_if.data)))
      else $error("fall enable clear wrong");
   frozen_state_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      !i_ce
      |=> ($stable(rise_if.value) && $stable(fall_if.value) && $stable(latch_ff)))
      else $error("state moved while frozen");

   // ----------------------------------------------------------------
   // Checks: source levels
   // ----------------------------------------------------------------
   // Levels lag the pins by two flops; skip cycles touched by reset or freeze
   id_ground_sync_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      ($past(i_ce) && $past(i_ce, 2) && !$past(i_sys_rst, 2))
      |-> (level[otg_event_pkg::BIT_ID_GROUND] == $past(i_id_ground_level, 2)))
      else $error("id ground level wrong");
   session_end_sync_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      ($past(i_ce) && $past(i_ce, 2) && !$past(i_sys_rst, 2))
      |-> (level[otg_event_pkg::BIT_SESSION_END] == $past(i_session_end_level, 2)))
      else $error("session end level wrong");
   session_valid_sync_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      ($past(i_ce) && $past(i_ce, 2) && !$past(i_sys_rst, 2))
      |-> (level[otg_event_pkg::BIT_SESSION_VALID] == $past(i_session_valid_level, 2)))
      else $error("session valid level wrong");
   bus_power_sync_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      ($past(i_ce) && $past(i_ce, 2) && !$past(i_sys_rst, 2))
      |-> (level[otg_event_pkg::BIT_BUS_VLD] == $past(i_bus_power_valid_level, 2)))
      else $error("bus power level wrong");
   host_disc_sync_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      ($past(i_ce) && $past(i_ce, 2) && !$past(i_sys_rst, 2))
      |-> (level[otg_event_pkg::BIT_HOST_DISC] == $past(i_host_disconnect_level, 2)))
      else $error("host disconnect level wrong");

   // ----------------------------------------------------------------
   // Checks: events and latch
   // ----------------------------------------------------------------
   quiet_no_irq_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      (i_ce && hit == 5'h00)
      |=> (!o_irq && !o_rxcmd_req))
      else $error("interrupt without an enabled change");
   rxcmd_levels_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      i_ce
      |=> (o_rxcmd_levels == $past(level)))
      else $error("command levels wrong");
   latch_read_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      (i_ce && latch_rd)
      |=> (o_reg_rdata == {otg_event_pkg::RSVD_ZERO, $past(latch_ff)}))
      else $error("latch read wrong");
   latch_rd_clear_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      (i_ce && latch_rd)
      |=> (latch_ff == $past(hit)))
      else $error("latch read did not clear");
   latch_update_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      (i_ce && !latch_rd && !i_low_power)
      |=> (latch_ff == ($past(latch_ff) | $past(hit))))
      else $error("latch lost or gained a bit");
endmodule

// ### hdl/otg_event_pkg.sv
package otg_event_pkg;

   // ----------------------------------------------------------------
   // Register addresses
   // ----------------------------------------------------------------
   localparam logic [5:0] ADDR_RISE_WR  = 6'h0d;
   localparam logic [5:0] ADDR_RISE_SET = 6'h0e;
   localparam logic [5:0] ADDR_RISE_CLR = 6'h0f;
   localparam logic [5:0] ADDR_FALL_WR  = 6'h10;
   localparam logic [5:0] ADDR_FALL_SET = 6'h11;
   localparam logic [5:0] ADDR_FALL_CLR = 6'h12;
   localparam logic [5:0] ADDR_LEVELS   = 6'h13;
   localparam logic [5:0] ADDR_LATCH    = 6'h14;
   localparam logic [5:0] ADDR_SET_STEP = 6'h01;
   localparam logic [5:0] ADDR_CLR_STEP = 6'h02;

   // ----------------------------------------------------------------
   // Field layout and reset values
   // ----------------------------------------------------------------
   localparam int         NUM_SRC       = 5;
   localparam int         BIT_ID_GROUND     = 4;
   localparam int         BIT_SESSION_END   = 3;
   localparam int         BIT_SESSION_VALID = 2;
   localparam int         BIT_BUS_VLD   = 1;
   localparam int         BIT_HOST_DISC = 0;
   localparam logic [4:0] ENABLE_RESET  = 5'h1f;
   localparam logic [4:0] LATCH_RESET   = 5'h00;
   localparam logic [2:0] RSVD_ZERO     = 3'h0;

   // Kind of enable write
   typedef enum logic [2:0] {
      WR_NONE = 3'b000,
      WR_LOAD = 3'b001,
      WR_SET  = 3'b010,
      WR_CLR  = 3'b100
   } wr_kind_e;

endpackage

// ### hdl/otg_event_if.sv
`timescale 1ns/1ps
// Carries one enable register's write request
interface enable_wr_if;
   otg_event_pkg::wr_kind_e kind;
   logic [4:0]              data;
   logic [4:0]              value;

   modport requester (output kind, output data, input value);
   modport holder    (input kind, input data, output value);
endinterface

// ### hdl/otg_enable_reg.sv
`timescale 1ns/1ps
module otg_enable_reg (
   input  wire logic        i_clk,
   input  wire logic        i_sys_rst,
   input  wire logic        i_ce,
   enable_wr_if.holder      wr
);
   logic [4:0] value_ff;
   logic [4:0] nxt_value;

   // ----------------------------------------------------------------
   // Write, set and clear decoding
   // ----------------------------------------------------------------
   assign nxt_value = (wr.kind == otg_event_pkg::WR_LOAD) ? wr.data :
                      (wr.kind == otg_event_pkg::WR_SET)  ? (value_ff | wr.data) :
                      (wr.kind == otg_event_pkg::WR_CLR)  ? (value_ff & ~wr.data) :
                      value_ff;
   assign wr.value  = value_ff;

   // All sources enabled out of reset
   always_ff @(posedge i_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         value_ff <= otg_event_pkg::ENABLE_RESET;
      end else if (i_ce) begin
         value_ff <= nxt_value;
      end
   end

   set_then_or_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      (i_ce && wr.kind == otg_event_pkg::WR_SET) |=> ((value_ff & $past(wr.data)) == $past(wr.data)))
      else $error("set write did not take ones");
   clr_then_zero_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      (i_ce && wr.kind == otg_event_pkg::WR_CLR) |=> ((value_ff & $past(wr.data)) == 5'h00))
      else $error("clear write left ones");
endmodule

// ### hdl/otg_edge_detect.sv
`timescale 1ns/1ps
module otg_edge_detect (
   input  wire logic        i_clk,
   input  wire logic        i_sys_rst,
   input  wire logic        i_ce,
   input  wire logic [4:0]  i_raw,
   output logic [4:0]       o_level,
   output logic [4:0]       o_rise,
   output logic [4:0]       o_fall
);
   logic [4:0] meta_ff;
   logic [4:0] sync_ff;
   logic [4:0] prev_ff;

   // ----------------------------------------------------------------
   // Two-stage sync; analog detectors are asynchronous
   // ----------------------------------------------------------------
   always_ff @(posedge i_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         meta_ff <= 5'h00;
         sync_ff <= 5'h00;
         prev_ff <= 5'h00;
      end else if (i_ce) begin
         meta_ff <= i_raw;
         sync_ff <= meta_ff;
         prev_ff <= sync_ff;
      end
   end

   // Edges from the settled copy only
   assign o_level = sync_ff;
   assign o_rise  = sync_ff & ~prev_ff;
   assign o_fall  = ~sync_ff & prev_ff;
endmodule

// ### verif/ulpi_link_model.sv
`timescale 1ns/1ps
// ----------------------------------------
// Link controller side of the register bus
// ----------------------------------------
module ulpi_link_model (
   input  wire logic       i_clk,
   input  wire logic [7:0] i_reg_rdata,
   input  wire logic       i_reg_rvalid,
   input  wire logic       i_rxcmd_req,
   input  wire logic [4:0] i_rxcmd_levels,
   output logic            o_reg_wr = 1'b0,
   output logic            o_reg_rd = 1'b0,
   output logic [5:0]      o_reg_addr = 6'h3f,
   output logic [7:0]      o_reg_wdata = 8'h00
);
   int         n_evt = 0;
   logic [4:0] evt_levels = 5'h00;

   // Idle bus shows the inverse, so a stale value never looks valid
   task automatic wr(input logic [5:0] a, input logic [7:0] d);
      @(negedge i_clk);
      o_reg_addr = a;
      o_reg_wdata = d;
      o_reg_wr = 1'b1;
      @(negedge i_clk);
      o_reg_wr = 1'b0;
      o_reg_addr = ~a;
      o_reg_wdata = ~d;
   endtask

   // Read strobe for one cycle, data taken with the valid pulse
   task automatic rd(input logic [5:0] a, output logic [7:0] d);
      int i;
      @(negedge i_clk);
      o_reg_addr = a;
      o_reg_rd = 1'b1;
      @(negedge i_clk);
      o_reg_rd = 1'b0;
      o_reg_addr = ~a;
      for (i = 0; i < 4 && i_reg_rvalid !== 1'b1; i++) @(negedge i_clk);
      d = (i_reg_rvalid === 1'b1) ? i_reg_rdata : 8'hxx;
   endtask

   // Receive commands counted as they are requested
   always @(posedge i_clk) begin
      if (i_rxcmd_req === 1'b1) begin
         n_evt <= n_evt + 1;
         evt_levels <= i_rxcmd_levels;
      end
   end
endmodule

// ### verif/usb_otg_event_edge_enables_tb_top.sv
`timescale 1ns/1ps
module usb_otg_event_edge_enables_tb_top;
   logic       clk = 1'b0, rst = 1'b1, ce = 1'b1, lp = 1'b0;
   logic [4:0] lv = 5'h00, prev = 5'h00, m_rise = 5'h1f, m_fall = 5'h1f, m_latch = 5'h00, r;
   logic       wr, rd, rvalid, irq, rxreq;
   logic [5:0] addr;
   logic [7:0] wdata, rdata, v;
   logic [4:0] rxlv;
   int         n_mismatch = 0, checked = 0, cyc = 0, n_irq = 0, exp_evt = 0, i, k;

   // ----------------
   // Clock and design
   // ----------------
   initial forever #2 clk = ~clk;

   otg_event_enables otg_event_enables_inst (.i_clk(clk), .i_sys_rst(rst), .i_ce(ce),
      .i_id_ground_level(lv[4]), .i_session_end_level(lv[3]),
      .i_session_valid_level(lv[2]), .i_bus_power_valid_level(lv[1]),
      .i_host_disconnect_level(lv[0]), .i_low_power(lp), .i_reg_wr(wr), .i_reg_rd(rd),
      .i_reg_addr(addr), .i_reg_wdata(wdata), .o_reg_rdata(rdata), .o_reg_rvalid(rvalid),
      .o_irq(irq), .o_rxcmd_req(rxreq), .o_rxcmd_levels(rxlv));

   ulpi_link_model ulpi_link_model_inst (.i_clk(clk), .i_reg_rdata(rdata),
      .i_reg_rvalid(rvalid), .i_rxcmd_req(rxreq), .i_rxcmd_levels(rxlv), .o_reg_wr(wr),
      .o_reg_rd(rd), .o_reg_addr(addr), .o_reg_wdata(wdata));

   // Interrupt pulses counted; cycle ceiling cuts a hang short
   always @(posedge clk) begin
      if (irq === 1'b1) n_irq <= n_irq + 1;
      cyc <= cyc + 1;
      if (cyc > 20000) begin
         n_mismatch = n_mismatch + 1;
         report_and_stop();
      end
   end

   // ----------------
   // Checking helpers
   // ----------------
   function automatic logic [4:0] hits(input logic [4:0] o, n, rr, ff);
      return (rr & ~o & n) | (ff & o & ~n);
   endfunction

   task automatic check(input string nm, input logic [7:0] e, input logic [7:0] g);
      checked++;
      if (g !== e) begin
         n_mismatch++;
         $display("wrong value %s expected %h seen %h", nm, e, g);
      end
   endtask

   task automatic rdchk(input logic [5:0] a, input logic [7:0] e);
      logic [7:0] d;
      ulpi_link_model_inst.rd(a, d);
      check($sformatf("reg %h", a), e, d);
   endtask

   // Level change, then event count, sampled levels and status read
   task automatic move(input logic [4:0] n);
      logic [4:0] e;
      e = hits(prev, n, m_rise, m_fall);
      exp_evt += (e != 5'h00);
      @(negedge clk);
      lv = n;
      repeat (6) @(negedge clk);
      check("irq count", 8'(exp_evt), 8'(n_irq));
      check("rxcmd count", 8'(exp_evt), 8'(ulpi_link_model_inst.n_evt));
      if (e != 5'h00)
         check("rxcmd lv", {3'h0, n}, {3'h0, ulpi_link_model_inst.evt_levels});
      m_latch |= e;
      prev = n;
      rdchk(otg_event_pkg::ADDR_LEVELS, {3'h0, n});
   endtask

   task automatic report_and_stop;
      if (n_mismatch == 0 && checked > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask

   // ----------------
   // Main sequence
   // ----------------
   initial begin
      void'($urandom(22));
      repeat (6) @(negedge clk);
      rst = 1'b0;
      for (i = 13; i < 19; i++) rdchk(6'(i), 8'h1f);
      rdchk(otg_event_pkg::ADDR_LATCH, 8'h00);
      ulpi_link_model_inst.wr(6'h20, 8'hff);
      rdchk(6'h20, 8'h00);
      // Each source rises then falls alone, all edges enabled
      for (i = 0; i < 5; i++) begin
         move(prev ^ (5'h01 << i));
         move(prev ^ (5'h01 << i));
      end
      rdchk(otg_event_pkg::ADDR_LATCH, {3'h0, m_latch});
      m_latch = 5'h00;
      rdchk(otg_event_pkg::ADDR_LATCH, 8'h00);
      // Random load, set and clear, with random reserved bits in the data
      for (i = 0; i < 24; i++) begin
         k = $urandom % 6;
         v = 8'($urandom);
         ulpi_link_model_inst.wr(6'h0d + 6'(k), v);
         r = (k < 3) ? m_rise : m_fall;
         r = (k % 3 == 0) ? v[4:0] : (k % 3 == 1) ? (r | v[4:0]) : (r & ~v[4:0]);
         if (k < 3) m_rise = r;
         else m_fall = r;
         rdchk(6'h0d + 6'(3 * (k / 3) + $urandom % 3), {3'h0, r});
         move(5'($urandom));
      end
      rdchk(otg_event_pkg::ADDR_LATCH, {3'h0, m_latch});
      m_latch = 5'h00;
      // Low power wipes the latch
      ulpi_link_model_inst.wr(otg_event_pkg::ADDR_RISE_SET, 8'h1f);
      ulpi_link_model_inst.wr(otg_event_pkg::ADDR_FALL_SET, 8'h1f);
      m_rise = 5'h1f;
      m_fall = 5'h1f;
      move(~prev);
      lp = 1'b1;
      repeat (2) @(negedge clk);
      lp = 1'b0;
      rdchk(otg_event_pkg::ADDR_LATCH, 8'h00);
      // Frozen clock enable ignores a write
      ce = 1'b0;
      ulpi_link_model_inst.wr(otg_event_pkg::ADDR_RISE_WR, 8'h00);
      ce = 1'b1;
      rdchk(otg_event_pkg::ADDR_RISE_WR, 8'h1f);
      // Second reset in mid-run restores enables; falls masked first
      ulpi_link_model_inst.wr(otg_event_pkg::ADDR_FALL_CLR, 8'h1f);
      m_fall = 5'h00;
      move(5'h00);
      rst = 1'b1;
      repeat (2) @(negedge clk);
      rst = 1'b0;
      rdchk(otg_event_pkg::ADDR_FALL_WR, 8'h1f);
      report_and_stop();
   end
endmodule
